// File: common/uhif_pkg.sv
// Constants and types for the USB host interrupt flag block
//
// Contract
// - Each internal event sets its pending flag, which stays set until cleared.
// - Interrupt request is high when a flag, its enable and master enable are set.
// - Host writing 1 clears a pending flag; 0 leaves it; host cannot set flags.
// - Event logic only sets pending flags; only host writes clear them.
// - Flag 6 sets when root hub or either downstream port state changes.
// - Flag 5 sets when frame index counter bit 15 toggles either way.
// - Flag 4 sets on a system error unrelated to USB traffic.
// - After fatal error flag, halt all schedule processing and bus signaling.
// - Flag 3 sets when downstream resume signaling starts after none.
// - Resume flag not set when driver itself enters the resume state.
// - Flag 2 sets at each frame start together with the start token.
// - Flag 0 sets when the periodic schedule overruns the frame time.
// - Each overrun also increments the overrun counter in command state register.
// - Enable bits sit at the same positions as the flags they gate.
// - Enable write sets bits written 1, leaves bits written 0.
// - Enable read returns present contents including master enable.
// - Enable bit 31 is master enable; writing 1 turns interrupts on.
// - Writing 0 to master enable is ignored; disabling uses disable register.
// - Disable register at code 85 clears bits written 1, reads enable contents.
// - Two-bit overrun counter resets to 00, wraps after 11, always increments.
package uhif_pkg;

  // ==========================================
  // Command codes
  localparam logic [7:0] CMD_RD_PENDING  = 8'h03;
  localparam logic [7:0] CMD_RD_ENABLE   = 8'h04;
  localparam logic [7:0] CMD_RD_DISABLE  = 8'h05;
  localparam logic [7:0] CMD_WR_PENDING  = 8'h83;
  localparam logic [7:0] CMD_WR_ENABLE   = 8'h84;
  localparam logic [7:0] CMD_WR_DISABLE  = 8'h85;

  // ==========================================
  // Field positions
  localparam int unsigned BIT_ROOT_HUB_CHANGE   = 6;
  localparam int unsigned BIT_FRAME_OVERFLOW    = 5;
  localparam int unsigned BIT_FATAL_ERROR       = 4;
  localparam int unsigned BIT_RESUME_DETECT     = 3;
  localparam int unsigned BIT_FRAME_START       = 2;
  localparam int unsigned BIT_SCHED_OVERRUN     = 0;
  localparam int unsigned BIT_MASTER_IRQ_ENABLE = 31;
  localparam int unsigned FRAME_MSB             = 15;

  // ==========================================
  // Masks and reset values
  localparam logic [31:0] FLAG_MASK      = 32'h0000_007D;
  localparam logic [31:0] ENABLE_MASK    = 32'h8000_007D;
  localparam logic [31:0] PENDING_RESET  = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET   = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO      = 32'h0000_0000;
  localparam logic [1:0]  OVERRUN_RESET  = 2'h0;
  localparam logic [1:0]  OVERRUN_STEP   = 2'h1;
  localparam logic [1:0]  STATE_RESUME   = 2'h1;

  // ==========================================
  // Types
  typedef enum logic [0:0] {
    UHIF_RUN  = 1'b0,
    UHIF_HALT = 1'b1
  } uhif_halt_type;

  // Keeps only the implemented bit positions of a word
  function automatic logic [31:0] uhif_keep(input logic [31:0] word, input logic [31:0] mask);
    uhif_keep = word & mask;
  endfunction : uhif_keep

endpackage : uhif_pkg

// File: common/uhif_event_if.sv
// Event strobes passed from the event detector to the flag logic
interface uhif_event_if;
  logic [31:0] set_vec;
  logic        overrun;

  modport src (
    output set_vec,
    output overrun
  );

  modport snk (
    input  set_vec,
    input  overrun
  );
endinterface : uhif_event_if

// File: logic/uhif_event_detect.sv
// Turns raw controller conditions into one-cycle flag set strobes
module uhif_event_detect (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_clear,
  input  wire logic [31:0] i_root_hub_state_reg,
  input  wire logic [31:0] i_downstream_port_state_reg1,
  input  wire logic [31:0] i_downstream_port_state_reg2,
  input  wire logic        i_frame_index_msb,
  input  wire logic        i_sys_error,
  input  wire logic        i_resume_signal,
  input  wire logic [1:0]  i_func_state,
  input  wire logic        i_frame_start,
  input  wire logic        i_sched_overrun,
  uhif_event_if.src        evt
);

  // ==========================================
  // History
  logic [95:0] hub_prev;
  logic        msb_prev;
  logic        err_prev;
  logic        res_prev;
  logic        primed;

  wire logic [95:0] hub_now = {i_root_hub_state_reg,
                               i_downstream_port_state_reg1,
                               i_downstream_port_state_reg2};
  // First sample after reset only loads history, so no false change is seen
  wire logic hub_chg = primed && (hub_now != hub_prev);
  wire logic msb_chg = primed && (i_frame_index_msb != msb_prev);
  wire logic err_rise = i_sys_error && !err_prev;
  // Driver-entered resume state masks resume detection
  wire logic res_rise = i_resume_signal && !res_prev
                        && (i_func_state != uhif_pkg::STATE_RESUME);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hub_prev <= '0;
      msb_prev <= 1'b0;
      err_prev <= 1'b0;
      res_prev <= 1'b0;
      primed   <= 1'b0;
    end else begin
      hub_prev <= hub_now;
      msb_prev <= i_frame_index_msb;
      err_prev <= i_sys_error;
      res_prev <= i_resume_signal;
      primed   <= !i_clear;
    end
  end

  always_comb begin
    evt.set_vec = '0;
    evt.set_vec[uhif_pkg::BIT_ROOT_HUB_CHANGE] = hub_chg;
    evt.set_vec[uhif_pkg::BIT_FRAME_OVERFLOW]  = msb_chg;
    evt.set_vec[uhif_pkg::BIT_FATAL_ERROR]     = err_rise;
    evt.set_vec[uhif_pkg::BIT_RESUME_DETECT]   = res_rise;
    evt.set_vec[uhif_pkg::BIT_FRAME_START]     = i_frame_start;
    evt.set_vec[uhif_pkg::BIT_SCHED_OVERRUN]   = i_sched_overrun;
    evt.overrun = i_sched_overrun;
  end

endmodule : uhif_event_detect

// File: logic/uhif_overrun_count.sv
// Two-bit scheduling overrun counter
module uhif_overrun_count (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_clear,
  uhif_event_if.snk       evt,
  output logic      [1:0] o_count
);

  // ==========================================
  // Counter
  logic [1:0] next_count;

  // Counts regardless of flag state; wraps naturally at two bits
  assign next_count = evt.overrun ? o_count + uhif_pkg::OVERRUN_STEP
                                  : o_count;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_count <= uhif_pkg::OVERRUN_RESET;
    end else if (i_clear) begin
      o_count <= uhif_pkg::OVERRUN_RESET;
    end else begin
      o_count <= next_count;
    end
  end

endmodule : uhif_overrun_count

// File: logic/uhif_top.sv
// Interrupt pending flags, enable mask and request logic of the host controller
module uhif_top (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_sw_reset,
  input  wire logic        i_cmd_valid,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic [31:0] i_cmd_wdata,
  output logic      [31:0] o_rd_data,
  output logic             o_rd_valid,
  output logic             o_cmd_unmapped,
  input  wire logic [31:0] i_root_hub_state_reg,
  input  wire logic [31:0] i_downstream_port_state_reg1,
  input  wire logic [31:0] i_downstream_port_state_reg2,
  input  wire logic        i_frame_index_msb,
  input  wire logic        i_sys_error,
  input  wire logic        i_resume_signal,
  input  wire logic [1:0]  i_func_state,
  input  wire logic        i_frame_start,
  input  wire logic        i_sched_overrun,
  output logic             o_irq,
  output logic      [31:0] o_pending_flags,
  output logic      [31:0] o_enable_mask,
  output logic      [1:0]  o_overrun_count,
  output logic             o_halt
);

  // ==========================================
  // Event detection
  uhif_event_if evt ();

  uhif_event_detect u_detect (
    .i_clk_sys                    (i_clk_sys),
    .i_rst                        (i_rst),
    .i_clear                      (i_sw_reset),
    .i_root_hub_state_reg         (i_root_hub_state_reg),
    .i_downstream_port_state_reg1 (i_downstream_port_state_reg1),
    .i_downstream_port_state_reg2 (i_downstream_port_state_reg2),
    .i_frame_index_msb            (i_frame_index_msb),
    .i_sys_error                  (i_sys_error),
    .i_resume_signal              (i_resume_signal),
    .i_func_state                 (i_func_state),
    .i_frame_start                (i_frame_start),
    .i_sched_overrun              (i_sched_overrun),
    .evt                          (evt)
  );

  uhif_overrun_count u_count (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_clear   (i_sw_reset),
    .evt       (evt),
    .o_count   (o_overrun_count)
  );

  // ==========================================
  // Command decode
  wire logic wr_pending = i_cmd_valid && (i_cmd_code == uhif_pkg::CMD_WR_PENDING);
  wire logic wr_enable  = i_cmd_valid && (i_cmd_code == uhif_pkg::CMD_WR_ENABLE);
  wire logic wr_disable = i_cmd_valid && (i_cmd_code == uhif_pkg::CMD_WR_DISABLE);
  wire logic rd_pending = i_cmd_valid && (i_cmd_code == uhif_pkg::CMD_RD_PENDING);
  wire logic rd_enable  = i_cmd_valid && (i_cmd_code == uhif_pkg::CMD_RD_ENABLE);
  wire logic rd_disable = i_cmd_valid && (i_cmd_code == uhif_pkg::CMD_RD_DISABLE);

  wire logic rd_any  = rd_pending || rd_enable || rd_disable;
  wire logic wr_any  = wr_pending || wr_enable || wr_disable;
  // Unknown read codes (bit 7 clear) are answered with zero; unknown write codes get no read response
  wire logic unmapped = i_cmd_valid && !rd_any && !wr_any;
  wire logic rd_cycle = rd_any || (unmapped && !i_cmd_code[7]);

  // ==========================================
  // Write masks, reserved bits dropped
  wire logic [31:0] clr_bits = wr_pending
                               ? uhif_pkg::uhif_keep(i_cmd_wdata, uhif_pkg::FLAG_MASK)
                               : '0;
  // Zeros are ignored, master enable included
  wire logic [31:0] en_set   = wr_enable
                               ? uhif_pkg::uhif_keep(i_cmd_wdata, uhif_pkg::ENABLE_MASK)
                               : '0;
  wire logic [31:0] en_clr   = wr_disable
                               ? uhif_pkg::uhif_keep(i_cmd_wdata, uhif_pkg::ENABLE_MASK)
                               : '0;

  // ==========================================
  // Pending flags
  logic [31:0] flags;
  logic [31:0] next_flags;
  wire logic [31:0] set_bits = uhif_pkg::uhif_keep(evt.set_vec, uhif_pkg::FLAG_MASK);

  // Set beats clear, so an event landing on a host clear survives;
  // events only ever OR bits in, and clears come only from host writes
  assign next_flags = (flags & ~clr_bits) | set_bits;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      flags <= uhif_pkg::PENDING_RESET;
    end else if (i_sw_reset) begin
      flags <= uhif_pkg::PENDING_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // ==========================================
  // Enable mask
  logic [31:0] enables;
  logic [31:0] next_enables;

  // Same positions as the flags; a disable on the same cycle is a separate code
  assign next_enables = (enables | en_set) & ~en_clr;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      enables <= uhif_pkg::ENABLE_RESET;
    end else if (i_sw_reset) begin
      enables <= uhif_pkg::ENABLE_RESET;
    end else begin
      enables <= next_enables;
    end
  end

  // ==========================================
  // Interrupt request
  wire logic master_on  = enables[uhif_pkg::BIT_MASTER_IRQ_ENABLE];
  wire logic any_active = |(flags & enables & uhif_pkg::FLAG_MASK);

  // Driven from registered flags and enables, never from the event strobe
  assign o_irq = master_on && any_active;

  // ==========================================
  // Halt control
  uhif_pkg::uhif_halt_type halt_state;
  uhif_pkg::uhif_halt_type next_halt_state;
  wire logic fatal_set = set_bits[uhif_pkg::BIT_FATAL_ERROR];

  // Only a controller reset with system error low releases the halt; that reset also clears the flag
  always_comb begin
    next_halt_state = halt_state;
    unique case (halt_state)
      uhif_pkg::UHIF_RUN: begin
        if (fatal_set) begin
          next_halt_state = uhif_pkg::UHIF_HALT;
        end
      end
      uhif_pkg::UHIF_HALT: begin
        if (i_sw_reset && !i_sys_error) begin
          next_halt_state = uhif_pkg::UHIF_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      halt_state <= uhif_pkg::UHIF_RUN;
    end else begin
      halt_state <= next_halt_state;
    end
  end

  assign o_halt = (halt_state == uhif_pkg::UHIF_HALT);

  // ==========================================
  // Read path
  logic [31:0] rd_sel;

  // Disable code reads back the enable mask
  always_comb begin
    rd_sel = uhif_pkg::READ_ZERO;
    if (rd_pending) begin
      rd_sel = uhif_pkg::uhif_keep(flags, uhif_pkg::FLAG_MASK);
    end else if (rd_enable || rd_disable) begin
      rd_sel = uhif_pkg::uhif_keep(enables, uhif_pkg::ENABLE_MASK);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data      <= uhif_pkg::READ_ZERO;
      o_rd_valid     <= 1'b0;
      o_cmd_unmapped <= 1'b0;
    end else begin
      o_rd_data      <= rd_cycle ? rd_sel : o_rd_data;
      o_rd_valid     <= rd_cycle;
      o_cmd_unmapped <= unmapped;
    end
  end

  // ==========================================
  // State views
  assign o_pending_flags = flags;
  assign o_enable_mask   = enables;

endmodule : uhif_top

// File: sim/uhif_chk.sv
// Port-level assertions for the interrupt flag block
module uhif_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_sw_reset,
  input wire logic        i_cmd_valid,
  input wire logic [7:0]  i_cmd_code,
  input wire logic [31:0] i_cmd_wdata,
  input wire logic        i_sys_error,
  input wire logic        i_frame_start,
  input wire logic        i_sched_overrun,
  input wire logic        o_irq,
  input wire logic [31:0] o_pending_flags,
  input wire logic [31:0] o_enable_mask,
  input wire logic [1:0]  o_overrun_count,
  input wire logic        o_halt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Properties
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_cmd(logic [7:0] code);
    i_cmd_valid && i_cmd_code == code && !i_sw_reset;
  endsequence
  sequence s_ovr;
    i_sched_overrun && !i_sw_reset;
  endsequence
  a_irq_gating: assert property (
    o_irq == (o_enable_mask[31] && |(o_pending_flags & o_enable_mask)))
    else $error("irq does not follow flags and enables");
  a_overrun_flag: assert property (s_ovr |=> o_pending_flags[0])
    else $error("overrun flag not set");
  a_overrun_step: assert property (
    s_ovr |=> o_overrun_count == $past(o_overrun_count) + 2'h1)
    else $error("overrun count did not step");
  a_frame_flag: assert property (i_frame_start && !i_sw_reset |=> o_pending_flags[2])
    else $error("frame start flag not set");
  a_flags_sticky: assert property (
    !i_sw_reset && !(i_cmd_valid && i_cmd_code == 8'h83)
    |=> (o_pending_flags & $past(o_pending_flags)) == $past(o_pending_flags))
    else $error("flag dropped without host clear");
  a_reserved_zero: assert property (
    (o_pending_flags & ~uhif_pkg::FLAG_MASK) == 32'h0
    && (o_enable_mask & ~uhif_pkg::ENABLE_MASK) == 32'h0)
    else $error("reserved bit set");
  a_write_clear: assert property (
    s_cmd(8'h83) ##0 !(i_sched_overrun || i_frame_start)
    |=> (o_pending_flags & $past(i_cmd_wdata) & 32'h0000_0005) == 32'h0)
    else $error("written one did not clear flag");
  a_enable_set: assert property (
    s_cmd(8'h84) |=> o_enable_mask
      == ($past(o_enable_mask) | ($past(i_cmd_wdata) & uhif_pkg::ENABLE_MASK)))
    else $error("enable write wrong");
  a_disable_clr: assert property (
    s_cmd(8'h85) |=> o_enable_mask == ($past(o_enable_mask) & ~$past(i_cmd_wdata)))
    else $error("disable write wrong");
  a_fatal_halt: assert property (
    $rose(i_sys_error) && !i_sw_reset |=> o_halt && o_pending_flags[4])
    else $error("fatal error did not halt");
endmodule : uhif_chk

bind uhif_top uhif_chk u_chk (.i_clk_sys, .i_rst, .i_sw_reset, .i_cmd_valid, .i_cmd_code,
  .i_cmd_wdata, .i_sys_error, .i_frame_start, .i_sched_overrun, .o_irq, .o_pending_flags,
  .o_enable_mask, .o_overrun_count, .o_halt);

// File: sim/uhif_host_model.sv
// Host driver model issuing register commands
module uhif_host_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rd_valid,
  input  wire logic [31:0] i_rd_data,
  output logic             o_cmd_valid,
  output logic      [7:0]  o_cmd_code,
  output logic      [31:0] o_cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code  = 8'h00;
    o_cmd_wdata = 32'h0000_0000;
  end
  // ==========================================
  // One command, one cycle strobe; clears only by writing ones
  task automatic cmd(input logic [7:0] code, input logic [31:0] data,
                     output logic [31:0] rd, output logic ok);
    @(negedge i_clk_sys);
    o_cmd_valid = 1'b1;
    o_cmd_code  = code;
    o_cmd_wdata = data;
    @(negedge i_clk_sys);
    ok = code[7] | (i_rd_valid === 1'b1);
    rd = i_rd_data;
    o_cmd_valid = 1'b0;
    // Released lines show a changed value so stale data never matches
    o_cmd_code  = ~code;
    o_cmd_wdata = ~data;
  endtask : cmd
endmodule : uhif_host_model

// File: sim/usb_host_interrupt_flags_tb.sv
// Self-checking bench for the interrupt flag block
module usb_host_interrupt_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys, i_rst, i_sw_reset, i_cmd_valid, o_rd_valid, o_cmd_unmapped, o_irq;
  logic [7:0]  i_cmd_code;
  logic [31:0] i_cmd_wdata, o_rd_data, o_pending_flags, o_enable_mask, rd, exp_flags, exp_en;
  logic [31:0] i_root_hub_state_reg, i_downstream_port_state_reg1, i_downstream_port_state_reg2;
  logic        i_frame_index_msb, i_sys_error, i_resume_signal, i_frame_start, i_sched_overrun;
  logic        o_halt, ok;
  logic [1:0]  i_func_state, o_overrun_count, exp_cnt;
  int          num_errors, total_checks;
  localparam int EBIT [7] = '{0, 2, 6, 6, 6, 5, 3};

  uhif_top u_dut (.i_clk_sys, .i_rst, .i_sw_reset, .i_cmd_valid, .i_cmd_code, .i_cmd_wdata,
    .o_rd_data, .o_rd_valid, .o_cmd_unmapped, .i_root_hub_state_reg,
    .i_downstream_port_state_reg1, .i_downstream_port_state_reg2, .i_frame_index_msb,
    .i_sys_error, .i_resume_signal, .i_func_state, .i_frame_start, .i_sched_overrun, .o_irq,
    .o_pending_flags, .o_enable_mask, .o_overrun_count, .o_halt);
  uhif_host_model u_host (.i_clk_sys, .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data),
    .o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code), .o_cmd_wdata(i_cmd_wdata));

  // ==========================================
  // Checking helpers
  function automatic logic f_irq(input logic [31:0] f, input logic [31:0] e);
    f_irq = e[31] & |(f & e & uhif_pkg::FLAG_MASK);
  endfunction : f_irq
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic check_all;
    chk("flags", exp_flags, o_pending_flags);
    chk("enable", exp_en, o_enable_mask);
    chk("count", {30'h0, exp_cnt}, {30'h0, o_overrun_count});
    chk("irq", {31'h0, f_irq(exp_flags, exp_en)}, {31'h0, o_irq});
  endtask : check_all
  task automatic cmd(input logic [7:0] code, input logic [31:0] data);
    u_host.cmd(code, data, rd, ok);
    chk("ok", 32'h1, {31'h0, ok});
    case (code)
      8'h83: exp_flags &= ~data;
      8'h84: exp_en |= data & uhif_pkg::ENABLE_MASK;
      8'h85: exp_en &= ~data;
      8'h03: chk("rd_flags", exp_flags, rd);
      default: chk("rd_enable", exp_en, rd);
    endcase
  endtask : cmd
  task automatic event_k(input int k);
    logic [1:0] st;
    st = 2'($urandom);
    @(negedge i_clk_sys);
    case (k)
      0: i_sched_overrun = 1'b1;
      1: i_frame_start = 1'b1;
      2: i_root_hub_state_reg ^= $urandom | 32'h1;
      3: i_downstream_port_state_reg1 ^= $urandom | 32'h1;
      4: i_downstream_port_state_reg2 ^= $urandom | 32'h1;
      5: i_frame_index_msb = ~i_frame_index_msb;
      default: begin
        i_func_state = st;
        i_resume_signal = 1'b1;
      end
    endcase
    @(negedge i_clk_sys);
    i_sched_overrun = 1'b0;
    i_frame_start = 1'b0;
    i_resume_signal = 1'b0;
    if (k != 6 || st != 2'h1) exp_flags[EBIT[k]] = 1'b1;
    if (k == 0) exp_cnt++;
  endtask : event_k
  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // ==========================================
  // Stimulus
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    repeat (100000) @(posedge i_clk_sys);
    num_errors++;
    results();
  end
  initial begin
    {i_rst, i_sw_reset, i_frame_index_msb, i_sys_error} = 4'h8;
    {i_resume_signal, i_frame_start, i_sched_overrun, i_func_state} = 5'h00;
    {i_root_hub_state_reg, i_downstream_port_state_reg1, i_downstream_port_state_reg2} = '0;
    {exp_flags, exp_en, exp_cnt} = '0;
    rd = $urandom(67);
    repeat (20) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    check_all();
    repeat (400) begin
      case ($urandom % 6)
        0, 1: event_k($urandom % 7);
        2: cmd(8'h84, $urandom);
        3: cmd(8'h85, $urandom & $urandom);
        4: cmd(8'h83, $urandom & $urandom);
        default: cmd(8'h03 + 8'($urandom % 3), $urandom);
      endcase
      check_all();
    end
    // Event against an all-ones clear in one cycle: event must survive
    fork
      u_host.cmd(8'h83, 32'hFFFF_FFFF, rd, ok);
      event_k(0);
    join
    exp_flags = 32'h0000_0001;
    check_all();
    u_host.cmd(8'h07, 32'h0, rd, ok);
    chk("unmapped", 32'h1, {31'h0, o_cmd_unmapped});
    chk("unmapped_rd", 32'h0, rd);
    cmd(8'h84, 32'h8000_0010);
    i_sys_error = 1'b1;
    @(negedge i_clk_sys);
    exp_flags[4] = 1'b1;
    check_all();
    repeat (5) @(negedge i_clk_sys);
    chk("halt", 32'h1, {31'h0, o_halt});
    i_sys_error = 1'b0;
    i_sw_reset = 1'b1;
    @(negedge i_clk_sys);
    i_sw_reset = 1'b0;
    {exp_flags, exp_en, exp_cnt} = '0;
    chk("halt_off", 32'h0, {31'h0, o_halt});
    check_all();
    cmd(8'h83, 32'h0000_0010);
    check_all();
    results();
  end
endmodule : usb_host_interrupt_flags_tb
